/* src/isq_qualifier.v */
`timescale 1ns/1ns
`default_nettype none
`include "isq_defs.vh"
// Source mode qualifier: samples the pixel clock and port on the system clock
module isq_qualifier #(
    parameter PIX_W = `ISQ_PIX_BITS
) (
    input wire i_sys_clk, // System reference clock, 50 MHz
    input wire i_reset, // Synchronous reset, active high
    input wire i_pclk, // Pixel clock from source
    input wire i_vsync, // Vertical sync, high active
    input wire i_hsync, // Horizontal sync, high active
    input wire i_data_en, // Active data enable
    input wire [PIX_W-1:0] i_pdata, // Pixel data
    input wire i_eye_select_input, // Eye select, high left
    input wire i_mode_3d, // Source announced as 3D
    input wire i_actuator_en, // System actuator enabled
    output reg [PIX_W-1:0] o_pdata, // Captured pixel data
    output reg o_pdata_valid, // Pixel data valid pulse
    output reg o_eye_left, // Current frame is left eye
    output reg [11:0] o_h_active, // Measured active pixels
    output reg [11:0] o_v_active, // Measured active lines
    output reg [`ISQ_CNT_W-1:0] o_frame_period, // Reference cycles per frame
    output reg o_frame_done, // New measurement pulse
    output reg o_mode_ok, // Source mode supported
    output reg o_unsupported, // Status flag: no mode matched
    output reg o_oversize // Image over display limit, raised only with actuator enabled
);
    // Two-stage synchronisers; first stages read only by second
    reg [3:0] meta;
    reg [3:0] sync;
    reg [PIX_W-1:0] pd_meta;
    reg [PIX_W-1:0] pd_sync;
    always @(posedge i_sys_clk)
    begin
        meta <= {i_pclk, i_vsync, i_hsync, i_data_en};
        sync <= meta;
        pd_meta <= i_pdata;
        pd_sync <= pd_meta;
    end
    wire pclk_s = sync[3];
    wire vs_s = sync[2];
    wire hs_s = sync[1];
    wire de_s = sync[0];

    // Eye select, 3D strap and actuator enable synchronised too
    reg [1:0] eye_meta;
    reg [1:0] eye_sync;
    reg act_meta;
    reg act_sync;
    always @(posedge i_sys_clk)
    begin
        eye_meta <= {i_eye_select_input, i_mode_3d};
        eye_sync <= eye_meta;
        act_meta <= i_actuator_en;
        act_sync <= act_meta;
    end

    // Edge detect on synchronised levels
    reg pclk_d;
    reg vs_d;
    reg hs_d;
    always @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            pclk_d <= 1'b0;
            vs_d <= 1'b0;
            hs_d <= 1'b0;
        end
        else
        begin
            pclk_d <= pclk_s;
            vs_d <= vs_s;
            hs_d <= hs_s;
        end
    end
    wire pclk_rise = pclk_s & ~pclk_d;
    wire vs_rise = vs_s & ~vs_d;
    wire hs_rise = hs_s & ~hs_d;

    // Pixel count per line sampled on pixel clock rise, line count per frame on line sync rise
    reg [11:0] pix_cnt;
    reg [11:0] line_cnt;
    reg line_had_de;
    reg de_prev;
    reg [`ISQ_CNT_W-1:0] ref_cnt;
    reg seen_vs;
    always @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            pix_cnt <= 12'h000;
            line_cnt <= 12'h000;
            line_had_de <= 1'b0;
            de_prev <= 1'b0;
            o_h_active <= 12'h000;
            o_v_active <= 12'h000;
            o_pdata <= {PIX_W{1'b0}};
            o_pdata_valid <= 1'b0;
        end
        else
        begin
            o_pdata_valid <= 1'b0;
            if (pclk_rise)
            begin
                de_prev <= de_s;
                // [R8] 24-bit pixel capture
                if (de_s)
                begin
                    o_pdata <= pd_sync;
                    o_pdata_valid <= 1'b1;
                    pix_cnt <= pix_cnt + 12'h001;
                    line_had_de <= 1'b1;
                end
                // Latch line width on falling data enable
                if (de_prev && !de_s)
                begin
                    o_h_active <= pix_cnt;
                    pix_cnt <= 12'h000;
                end
            end
            if (vs_rise)
            begin
                o_v_active <= line_cnt + {11'h000, line_had_de};
                line_cnt <= 12'h000;
                line_had_de <= 1'b0;
            end
            else if (hs_rise && line_had_de)
            begin
                line_cnt <= line_cnt + 12'h001;
                line_had_de <= 1'b0;
            end
        end
    end

    // [R15] reference count between sync edges
    always @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            ref_cnt <= {`ISQ_CNT_W{1'b0}};
            o_frame_period <= {`ISQ_CNT_W{1'b0}};
            o_frame_done <= 1'b0;
            seen_vs <= 1'b0;
        end
        else
        begin
            o_frame_done <= 1'b0;
            if (vs_rise)
            begin
                ref_cnt <= {`ISQ_CNT_W{1'b0}};
                seen_vs <= 1'b1;
                if (seen_vs)
                begin
                    o_frame_period <= ref_cnt + 1'b1;
                    o_frame_done <= 1'b1;
                end
            end
            else if (ref_cnt != {`ISQ_CNT_W{1'b1}})
            begin
                ref_cnt <= ref_cnt + 1'b1; // Saturates when sync stops
            end
        end
    end

    // [R10] eye latched at frame start
    // Eye level is stable around the sync edge by the source's setup/hold.
    always @(posedge i_sys_clk)
    begin
        if (i_reset)
            o_eye_left <= 1'b0;
        else if (vs_rise)
            o_eye_left <= eye_sync[1];
    end

    // Rate window matches, one per supported nominal rate
    wire [5:0] rate_hit;
    isq_rate_match #(.RATE_HZ(50)) u_r50 (.i_period(o_frame_period), .o_match(rate_hit[0]));
    isq_rate_match #(.RATE_HZ(60)) u_r60 (.i_period(o_frame_period), .o_match(rate_hit[1]));
    isq_rate_match #(.RATE_HZ(100)) u_r100 (.i_period(o_frame_period), .o_match(rate_hit[2]));
    isq_rate_match #(.RATE_HZ(120)) u_r120 (.i_period(o_frame_period), .o_match(rate_hit[3]));
    isq_rate_match #(.RATE_HZ(200)) u_r200 (.i_period(o_frame_period), .o_match(rate_hit[4]));
    isq_rate_match #(.RATE_HZ(240)) u_r240 (.i_period(o_frame_period), .o_match(rate_hit[5]));

    // [R5] exact landscape sizes only
    // Portrait (height over width) never equals these, so it is rejected.
    wire is_qhd = (o_h_active == `ISQ_QHD_W) && (o_v_active == `ISQ_QHD_H);
    wire is_fhd = (o_h_active == `ISQ_FHD_W) && (o_v_active == `ISQ_FHD_H);
    wire is_3d = eye_sync[0];
    // [R1] 2D quarter-HD at any of the six rates
    wire ok_2d_qhd = !is_3d && is_qhd && (|rate_hit);
    // [R2] 2D full-HD 50/60 only
    wire ok_2d_fhd = !is_3d && is_fhd && (rate_hit[0] | rate_hit[1]);
    // [R3] 3D quarter-HD 100/120 only
    wire ok_3d_qhd = is_3d && is_qhd && (rate_hit[2] | rate_hit[3]);
    // [R7] one port for both formats
    wire next_ok = ok_2d_qhd | ok_2d_fhd | ok_3d_qhd;
    // [R6] display size limit
    wire next_over = act_sync &&
        ((o_h_active > `ISQ_MAX_W) || (o_v_active > `ISQ_MAX_H));

    // [R14] status flag update
    // Judged two cycles after each new period so all measures are settled.
    reg judge;
    always @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            judge <= 1'b0;
            o_mode_ok <= 1'b0;
            o_unsupported <= 1'b0;
            o_oversize <= 1'b0;
        end
        else
        begin
            judge <= o_frame_done;
            if (judge)
            begin
                o_mode_ok <= next_ok;
                o_unsupported <= ~next_ok;
                o_oversize <= next_over;
            end
        end
    end
endmodule
`default_nettype wire

/* inc/isq_defs.vh */
// Notes on behaviour
// [R1] Accept 2D 960x540 at six listed rates
// [R2] Accept 2D 1920x1080 only at 50/60 Hz
// [R3] Accept 3D 960x540 only at 100/120 Hz
// [R4] Source sends 3D as alternating whole frames
// [R5] Portrait resolutions are always unsupported
// [R6] Displayed image limited to 1920x1080
// [R7] 2D and 3D share one pixel port
// [R8] Pixels carry at most 24 bits
// [R9] Source keeps interface within its limits
// [R10] Eye select high left, low right
// [R11] Eye select changes 1 ms before sync
// [R12] Eye select held 1 ms after sync
// [R13] One eye per frame, split by sync
// [R14] Flag raised when no mode matches
// [R15] Rate measured by reference clock count
`ifndef ISQ_DEFS_VH
`define ISQ_DEFS_VH
`define ISQ_CLK_HZ 50000000
`define ISQ_QHD_W 12'h3c0
`define ISQ_QHD_H 12'h21c
`define ISQ_FHD_W 12'h780
`define ISQ_FHD_H 12'h438
`define ISQ_MAX_W 12'h780
`define ISQ_MAX_H 12'h438
`define ISQ_TOL_HZ 2
`define ISQ_PIX_BITS 24
`define ISQ_CNT_W 24
`endif

/* src/isq_rate_match.v */
`timescale 1ns/1ns
`default_nettype none
`include "isq_defs.vh"
// Compares a frame period count against one nominal rate +/- tolerance
module isq_rate_match #(
    parameter RATE_HZ = 60
) (
    input wire [`ISQ_CNT_W-1:0] i_period, // Reference cycles per frame
    output wire o_match // Period within window
);
    // Longer period means lower rate, so low rate bound gives the upper count
    // Worked out in 32 bits, then cut to the counter width on purpose
    localparam integer MAX_FULL = `ISQ_CLK_HZ / (RATE_HZ - `ISQ_TOL_HZ);
    localparam integer MIN_FULL = `ISQ_CLK_HZ / (RATE_HZ + `ISQ_TOL_HZ);
    localparam [`ISQ_CNT_W-1:0] CNT_MAX = MAX_FULL[`ISQ_CNT_W-1:0];
    localparam [`ISQ_CNT_W-1:0] CNT_MIN = MIN_FULL[`ISQ_CNT_W-1:0];
    // [R15] tolerance window compare
    assign o_match = (i_period >= CNT_MIN) && (i_period <= CNT_MAX);
endmodule
`default_nettype wire

/* dv/isq_qualifier_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
module isq_chk (
    input wire logic i_sys_clk, // Clock
    input wire logic i_reset, // Reset
    input wire logic i_mode_3d, // 3D source
    input wire logic o_pdata_valid, // Pixel pulse
    input wire logic [11:0] o_h_active, // Width
    input wire logic [11:0] o_v_active, // Height
    input wire logic [23:0] o_frame_period, // Period
    input wire logic o_frame_done, // Done pulse
    input wire logic o_mode_ok, // Mode ok
    input wire logic o_unsupported // No mode
);
    // Period window for 48 Hz down to 242 Hz at 50 MHz
    localparam int MIN_P = 206611;
    localparam int MAX_P = 1041667;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);
    // A frame too short for any rate
    sequence s_short_done;
        o_frame_done && o_frame_period < MIN_P;
    endsequence
    a_short_frame_flag: assert property (s_short_done |-> ##2 o_unsupported && !o_mode_ok)
        else $error("short frame not flagged");
    a_status_exclusive: assert property (!(o_mode_ok && o_unsupported))
        else $error("ok and flag together");
    a_status_timing: assert property ($changed(o_unsupported) |-> $past(o_frame_done, 2))
        else $error("flag moved off judgement");
    a_ok_size: assert property ($rose(o_mode_ok) |->
        (o_h_active == 12'h3c0 && o_v_active == 12'h21c) ||
        (o_h_active == 12'h780 && o_v_active == 12'h438))
        else $error("ok on bad size");
    a_ok_period: assert property ($rose(o_mode_ok) |-> o_frame_period >= MIN_P &&
        o_frame_period <= MAX_P)
        else $error("ok on bad rate");
    // Only 100 or 120 Hz quarter size passes in 3D
    a_qhd_3d_only: assert property ($rose(o_mode_ok) && i_mode_3d |->
        o_h_active == 12'h3c0 && o_frame_period >= 409836 && o_frame_period <= 510205)
        else $error("bad 3D mode ok");
    a_period_with_done: assert property ($changed(o_frame_period) |-> o_frame_done)
        else $error("period moved without done");
    a_pixel_pulse: assert property (o_pdata_valid |=> !o_pdata_valid)
        else $error("pixel pulse too long");
endmodule
bind isq_qualifier isq_chk u_chk (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
    .i_mode_3d(i_mode_3d), .o_pdata_valid(o_pdata_valid), .o_h_active(o_h_active),
    .o_v_active(o_v_active), .o_frame_period(o_frame_period), .o_frame_done(o_frame_done),
    .o_mode_ok(o_mode_ok), .o_unsupported(o_unsupported));
`default_nettype wire

/* dv/isq_src_model.sv */
`timescale 1ns/1ns
`default_nettype none
// Upstream source; its pixel clock stands still between bursts
module isq_src (
    input wire logic i_sys_clk, // System clock
    output var logic o_pclk, // Pixel clock
    output var logic o_vsync, // Vertical sync
    output var logic o_hsync, // Line sync
    output var logic o_data_en, // Data enable
    output var logic [23:0] o_pdata // Pixel data
);
    initial
    begin
        o_pclk = 1'b0;
        o_vsync = 1'b0;
        o_hsync = 1'b0;
        o_data_en = 1'b0;
        o_pdata = 24'h000000;
    end
    // One whole pixel per 160 ns clock
    task automatic px(input logic [23:0] d, input logic de, input logic hs);
        begin
            o_pdata = de ? d : ~o_pdata; // Idle data inverts the previous value on every idle clock
            o_data_en = de;
            o_hsync = hs;
            repeat (4) @(negedge i_sys_clk);
            o_pclk = 1'b1;
            repeat (4) @(negedge i_sys_clk);
            o_pclk = 1'b0;
        end
    endtask
    // One eye per frame, opened by a vertical sync
    task automatic frame(input int lines, input int pix);
        begin
            o_vsync = 1'b1;
            repeat (4) px(24'h000000, 1'b0, 1'b0);
            o_vsync = 1'b0;
            for (int l = 0; l < lines; l++)
            begin
                for (int p = 0; p < pix; p++)
                    px({8'(l), 8'(p), 8'h5a}, 1'b1, 1'b0);
                repeat (8) px(24'h000000, 1'b0, 1'b0);
                repeat (4) px(24'h000000, 1'b0, 1'b1);
                repeat (4) px(24'h000000, 1'b0, 1'b0);
            end
        end
    endtask
endmodule
`default_nettype wire

/* dv/isq_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic i_sys_clk, i_reset, i_mode_3d, i_actuator_en, eye;
    logic pclk, vsync, hsync, de, o_pdata_valid, o_eye_left, o_frame_done;
    logic o_mode_ok, o_unsupported, o_oversize;
    logic [23:0] pdata, o_pdata, o_frame_period;
    logic [11:0] o_h_active, o_v_active;
    int n_mismatch = 0, cmp_count = 0, cycles = 0, n_done = 0, n_pix = 0;
    isq_src src (.i_sys_clk(i_sys_clk), .o_pclk(pclk), .o_vsync(vsync), .o_hsync(hsync),
        .o_data_en(de), .o_pdata(pdata));
    isq_qualifier uut (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_pclk(pclk),
        .i_vsync(vsync), .i_hsync(hsync), .i_data_en(de), .i_pdata(pdata),
        .i_eye_select_input(eye), .i_mode_3d(i_mode_3d), .i_actuator_en(i_actuator_en),
        .o_pdata(o_pdata), .o_pdata_valid(o_pdata_valid), .o_eye_left(o_eye_left),
        .o_h_active(o_h_active), .o_v_active(o_v_active), .o_frame_period(o_frame_period),
        .o_frame_done(o_frame_done), .o_mode_ok(o_mode_ok), .o_unsupported(o_unsupported),
        .o_oversize(o_oversize));
    initial
    begin
        i_sys_clk = 1'b0;
        forever #10 i_sys_clk = ~i_sys_clk;
    end
    task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
        begin
            cmp_count++;
            if (got !== exp)
            begin
                n_mismatch++;
                $display("wrong value %s expected %h seen %h", name, exp, got);
            end
        end
    endtask
    task automatic end_of_test;
        begin
            $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
            if (n_mismatch == 0 && cmp_count > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    // Event counts; the two-frame run needs about 100150 cycles
    always @(posedge i_sys_clk)
    begin
        cycles <= cycles + 1;
        n_done <= n_done + int'(o_frame_done === 1'b1);
        n_pix <= n_pix + int'(o_pdata_valid === 1'b1);
        if (cycles == 110000)
        begin
            n_mismatch++;
            end_of_test();
        end
    end
    task automatic test_reset;
        begin
            @(negedge i_sys_clk);
            chk("ok", 24'h0, {23'h0, o_mode_ok});
            chk("flag", 24'h0, {23'h0, o_unsupported});
            chk("period", 24'h0, o_frame_period);
        end
    endtask
    // Two 3D frames 100100 cycles apart, lines one pixel over the limit
    task automatic test_two_frames;
        begin
            src.frame(3, 1921);
            chk("done after first sync", 24'h0, n_done);
            chk("eye", 24'h1, {23'h0, o_eye_left});
            chk("width", 24'h781, {12'h0, o_h_active});
            chk("pixels", 24'h1683, n_pix);
            chk("pixel", 24'h02805a, o_pdata);
            repeat (3520) @(negedge i_sys_clk);
            // Eye flips 1 ms clear of both sync edges
            eye = 1'b0;
            repeat (50060) @(negedge i_sys_clk);
            src.frame(0, 0);
            repeat (8) @(negedge i_sys_clk);
            chk("done", 24'h1, n_done);
            chk("rate window", 24'h1, {23'h0, o_frame_period >= 100099 &&
                o_frame_period <= 100101});
            chk("lines", 24'h3, {12'h0, o_v_active});
            chk("eye", 24'h0, {23'h0, o_eye_left});
            chk("flag", 24'h1, {23'h0, o_unsupported});
            chk("ok", 24'h0, {23'h0, o_mode_ok});
            chk("oversize", 24'h1, {23'h0, o_oversize});
        end
    endtask
    initial
    begin
        i_reset = 1'b1;
        i_mode_3d = 1'b1;
        i_actuator_en = 1'b1;
        eye = 1'b1;
        repeat (12) @(negedge i_sys_clk);
        i_reset = 1'b0;
        test_reset();
        test_two_frames();
        end_of_test();
    end
endmodule
`default_nettype wire
